// ### design/lcd_shared_io_ports.sv
// How it works
// (R1) Port A is four bidirectional pins whose data sits in the output latch.
// (R2) Reset sets the port A output latch to f0.
// (R3) Port A bits set as outputs read back the latch value.
// (R4) Port A bits set as inputs read back the sampled pin level.
// (R5) Direction one drives the latched bit out; zero makes the pin an input.
// (R6) Latch and direction steer a pin only while LCD config leaves it general.
// (R7) Reset sets port A direction to f0, so all four pins are inputs.
// (R8) Port A direction is write-only and always reads as all ones.
// (R9) Pin 3 is common 4 if segments on and swap or duty 11.
// (R10) Pin 2 is common 3 if segments on and swap or duty above 01.
// (R11) Pin 2's neighbour pin 1 is common 2 if segments on and swap or duty nonzero.
// (R12) Pin 0 is common 1 whenever segment extension or segment select is nonzero.
// (R13) Pins float in reset and standby, hold in sleep, subsleep and watch, run otherwise.
// (R14) Port B is eight input-only pins behind a read-only register.
// (R15) Reading port B returns the present levels of its eight pins.
// (R16) Port C is four input-only pins in the low bits of a read-only register.
// (R17) Reading port C returns the present levels of its four pins.
// (R18) A pin chosen as the converter analog channel reads as zero.
// (R19) Port A latch bits 7 to 4 read one and ignore writes.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module lcd_shared_io_ports (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [lcd_port_pkg::ADDR_W-1:0] avAddress,
    input wire logic avRead,
    input wire logic avWrite,
    input wire logic [lcd_port_pkg::DATA_W-1:0] avWriteData,
    input wire logic [3:0] avByteEnable,
    output logic [lcd_port_pkg::DATA_W-1:0] avReadData,
    output logic avWaitRequest,
    output logic [1:0] avResponse,
    input wire logic [3:0] portaPinIn,
    output logic [3:0] portaPinOut,
    output logic [3:0] portaPinOe,
    input wire logic [3:0] lcdCommonDrive,
    input wire logic [7:0] portbPinIn,
    input wire logic [3:0] portcPinIn
);
    import lcd_port_pkg::*;

    // Returns which of a group of pins the converter channel currently claims
    function automatic logic [7:0] analog_mask(
        input logic [3:0] channel,
        input logic [3:0] first,
        input logic [3:0] count
    );
        logic [3:0] offset;
        logic [7:0] mask;
        offset = channel - first;
        mask = 8'h00;
        if ((channel >= first) && (offset < count)) begin
            mask[offset[2:0]] = 1'b1;
        end
        return mask;
    endfunction : analog_mask

    function automatic logic is_legal_power_mode(input logic [2:0] code);
        return code <= PWR_SUBACTIVE;
    endfunction : is_legal_power_mode

    // Bus handshake state
    bus_state_t busState_ff;
    bus_state_t nxt_busState;
    logic [DATA_W-1:0] avReadData_ff;
    logic [DATA_W-1:0] nxt_avReadData;
    logic avWaitRequest_ff;
    logic nxt_avWaitRequest;
    logic [1:0] avResponse_ff;
    logic [1:0] nxt_avResponse;

    // Software-visible registers
    logic [3:0] portaLatch_ff;
    logic [3:0] nxt_portaLatch;
    logic [3:0] portaDir_ff;
    logic [3:0] nxt_portaDir;
    lcd_cfg_t lcdPortControl_ff;
    lcd_cfg_t nxt_lcdPortControl;
    conv_mode_t convModeReg_ff;
    conv_mode_t nxt_convModeReg;
    pwr_mode_t powerMode_ff;
    pwr_mode_t nxt_powerMode;

    // Pin drivers
    logic [3:0] portaPinOut_ff;
    logic [3:0] nxt_portaPinOut;
    logic [3:0] portaPinOe_ff;
    logic [3:0] nxt_portaPinOe;

    // Decode and read-back helpers
    logic addrHit;
    logic [REG_W-1:0] readByte;
    logic [7:0] portbAnalogMask;
    logic [7:0] portcAnalogMask;
    logic [3:0] portaReadBits;
    logic writeNow;
    pin_drive_t [3:0] pinDrive;
    logic [3:0] pinIsCommon;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            port_a_pin_mux #(
                .PIN_INDEX(gi)
            ) u_pin_mux (
                .cfg(lcdPortControl_ff),
                .dirBit(portaDir_ff[gi]),
                .latchBit(portaLatch_ff[gi]),
                .commonDrive(lcdCommonDrive[gi]),
                .drive(pinDrive[gi]),
                .isCommon(pinIsCommon[gi])
            );
        end
    endgenerate

    always_comb begin
        portbAnalogMask = analog_mask(convModeReg_ff.analogChannelSelect, CHAN_PORTB_FIRST,
            4'h8);
        portcAnalogMask = analog_mask(convModeReg_ff.analogChannelSelect, CHAN_PORTC_FIRST,
            4'h4);
        // Output bits return the latch, input bits the pin, per bit
        portaReadBits = (portaDir_ff & portaLatch_ff) // see (R3)
            | (~portaDir_ff & portaPinIn); // see (R4)
    end

    always_comb begin
        addrHit = 1'b1;
        readByte = 8'h00;
        unique case (avAddress)
            IDX_PORTA_LATCH: readByte = {PORTA_UPPER_ONES, portaReadBits}; // see (R19)
            IDX_PORTA_DIR: readByte = DIR_READ_VALUE; // see (R8)
            IDX_PORTB_LEVELS: readByte = portbPinIn & ~portbAnalogMask; // see (R14) (R15) (R18)
            IDX_PORTC_LEVELS: begin
                readByte = {4'h0, portcPinIn & ~portcAnalogMask[3:0]}; // see (R16) (R17) (R18)
            end
            IDX_LCD_PORT_CTRL: readByte = lcdPortControl_ff;
            IDX_CONV_MODE: readByte = convModeReg_ff;
            IDX_POWER_MODE: readByte = {5'h00, powerMode_ff};
            default: addrHit = 1'b0;
        endcase
    end

    // Every request costs one idle cycle then one answer cycle; waitrequest
    // is a flop so the master sees a clean, glitch-free handshake.
    always_comb begin
        nxt_busState = busState_ff;
        nxt_avReadData = avReadData_ff;
        nxt_avWaitRequest = 1'b1;
        nxt_avResponse = avResponse_ff;
        unique case (busState_ff)
            BUS_IDLE: begin
                if (avRead || avWrite) begin
                    nxt_busState = BUS_ACK;
                    nxt_avWaitRequest = 1'b0;
                    nxt_avResponse = addrHit ? RESP_OKAY : RESP_DECODE_ERR;
                    nxt_avReadData = avRead ? {24'h000000, readByte} : '0;
                end
            end
            BUS_ACK: begin
                nxt_busState = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busState_ff <= BUS_IDLE;
            avReadData_ff <= '0;
            avWaitRequest_ff <= 1'b1;
            avResponse_ff <= RESP_OKAY;
        end else begin
            busState_ff <= nxt_busState;
            avReadData_ff <= nxt_avReadData;
            avWaitRequest_ff <= nxt_avWaitRequest;
            avResponse_ff <= nxt_avResponse;
        end
    end

    // A write lands on the edge where the master samples waitrequest low
    always_comb begin
        writeNow = (busState_ff == BUS_ACK) && avWrite && avByteEnable[0];
        nxt_portaLatch = portaLatch_ff;
        nxt_portaDir = portaDir_ff;
        nxt_lcdPortControl = lcdPortControl_ff;
        nxt_convModeReg = convModeReg_ff;
        nxt_powerMode = powerMode_ff;
        if (writeNow) begin
            unique case (avAddress)
                IDX_PORTA_LATCH: nxt_portaLatch = avWriteData[3:0]; // see (R1) (R19)
                IDX_PORTA_DIR: nxt_portaDir = avWriteData[3:0]; // see (R5)
                IDX_LCD_PORT_CTRL: nxt_lcdPortControl = avWriteData[REG_W-1:0];
                IDX_CONV_MODE: nxt_convModeReg = {4'h0, avWriteData[3:0]};
                IDX_POWER_MODE: begin
                    // Undefined mode codes are dropped so the mode stays legal
                    if (is_legal_power_mode(avWriteData[2:0])) begin
                        nxt_powerMode = pwr_mode_t'(avWriteData[2:0]);
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            portaLatch_ff <= PORTA_LATCH_RST[3:0]; // see (R2)
            portaDir_ff <= PORTA_DIR_RST[3:0]; // see (R7)
            lcdPortControl_ff <= LCD_PORT_CTRL_RST;
            convModeReg_ff <= CONV_MODE_RST;
            powerMode_ff <= POWER_MODE_RST;
        end else begin
            portaLatch_ff <= nxt_portaLatch;
            portaDir_ff <= nxt_portaDir;
            lcdPortControl_ff <= nxt_lcdPortControl;
            convModeReg_ff <= nxt_convModeReg;
            powerMode_ff <= nxt_powerMode;
        end
    end

    // The power mode gates the pin drivers; the pins lag a setting by one cycle.
    always_comb begin
        nxt_portaPinOut = portaPinOut_ff;
        nxt_portaPinOe = portaPinOe_ff;
        unique case (powerMode_ff)
            PWR_ACTIVE, PWR_SUBACTIVE: begin
                for (int i = 0; i < 4; i++) begin
                    nxt_portaPinOut[i] = pinDrive[i].out; // see (R13)
                    nxt_portaPinOe[i] = pinDrive[i].oe; // see (R13)
                end
            end
            PWR_SLEEP, PWR_SUBSLEEP, PWR_WATCH: begin
                // Frozen pins keep their last level and direction
            end
            PWR_STANDBY: begin
                nxt_portaPinOe = 4'h0; // see (R13)
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            portaPinOut_ff <= 4'h0;
            portaPinOe_ff <= 4'h0; // see (R13)
        end else begin
            portaPinOut_ff <= nxt_portaPinOut;
            portaPinOe_ff <= nxt_portaPinOe;
        end
    end

    assign avReadData = avReadData_ff;
    assign avWaitRequest = avWaitRequest_ff;
    assign avResponse = avResponse_ff;
    assign portaPinOut = portaPinOut_ff;
    assign portaPinOe = portaPinOe_ff;

endmodule : lcd_shared_io_ports

// ### pkg/lcd_port_pkg.sv
package lcd_port_pkg;

    // Avalon word addressing: one register per 32-bit word, data in the low byte
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    localparam logic [ADDR_W-1:0] IDX_PORTA_LATCH = 16'hffcd;
    localparam logic [ADDR_W-1:0] IDX_PORTA_DIR = 16'hffed;
    localparam logic [ADDR_W-1:0] IDX_PORTB_LEVELS = 16'hffde;
    localparam logic [ADDR_W-1:0] IDX_PORTC_LEVELS = 16'hffdf;
    localparam logic [ADDR_W-1:0] IDX_LCD_PORT_CTRL = 16'hffc0;
    localparam logic [ADDR_W-1:0] IDX_CONV_MODE = 16'hffc1;
    localparam logic [ADDR_W-1:0] IDX_POWER_MODE = 16'hffc2;

    localparam logic [REG_W-1:0] PORTA_LATCH_RST = 8'hf0;
    localparam logic [REG_W-1:0] PORTA_DIR_RST = 8'hf0;
    localparam logic [REG_W-1:0] LCD_PORT_CTRL_RST = 8'h00;
    localparam logic [REG_W-1:0] CONV_MODE_RST = 8'h00;
    localparam logic [REG_W-1:0] DIR_READ_VALUE = 8'hff;
    localparam logic [3:0] PORTA_UPPER_ONES = 4'hf;

    // Converter channel codes: below 4 no pin, 4..11 port B bit 0..7, 12..15 port C bit 0..3
    localparam logic [3:0] CHAN_PORTB_FIRST = 4'h4;
    localparam logic [3:0] CHAN_PORTC_FIRST = 4'hc;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECODE_ERR = 2'h3;

    // Byte layout of the LCD port control register, msb first
    typedef struct packed {
        logic [1:0] dutySelect;
        logic commonSwap;
        logic segmentExtension;
        logic [3:0] segmentSelect;
    } lcd_cfg_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

    typedef struct packed {
        logic [3:0] reserved;
        logic [3:0] analogChannelSelect;
    } conv_mode_t;

    typedef enum logic [2:0] {
        PWR_ACTIVE = 3'h0,
        PWR_SLEEP = 3'h1,
        PWR_SUBSLEEP = 3'h2,
        PWR_STANDBY = 3'h3,
        PWR_WATCH = 3'h4,
        PWR_SUBACTIVE = 3'h5
    } pwr_mode_t;

    localparam pwr_mode_t POWER_MODE_RST = PWR_ACTIVE;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

endpackage : lcd_port_pkg

// ### design/port_a_pin_mux.sv
`timescale 1ns/1ps

module port_a_pin_mux #(
    parameter int PIN_INDEX = 0
) (
    input wire lcd_port_pkg::lcd_cfg_t cfg,
    input wire logic dirBit,
    input wire logic latchBit,
    input wire logic commonDrive,
    output lcd_port_pkg::pin_drive_t drive,
    output logic isCommon
);
    import lcd_port_pkg::*;

    logic segmentsOn;

    always_comb begin
        segmentsOn = cfg.segmentExtension | (cfg.segmentSelect != 4'h0);
        unique case (PIN_INDEX)
            3: isCommon = segmentsOn & (cfg.commonSwap | (cfg.dutySelect == 2'h3)); // see (R9)
            2: isCommon = segmentsOn & (cfg.commonSwap | cfg.dutySelect[1]); // see (R10)
            1: isCommon = segmentsOn & (cfg.commonSwap | (cfg.dutySelect != 2'h0)); // see (R11)
            default: isCommon = segmentsOn; // see (R12)
        endcase
        if (isCommon) begin
            // Latch and direction are ignored while the LCD owns the pin
            drive.out = commonDrive; // see (R6)
            drive.oe = 1'b1;
        end else begin
            drive.out = latchBit; // see (R5)
            drive.oe = dirBit; // see (R5)
        end
    end

endmodule : port_a_pin_mux

// ### dv/lcd_shared_io_ports_properties.sv
`timescale 1ns/1ps
module lcd_shared_io_ports_checker
    import lcd_port_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [lcd_port_pkg::ADDR_W-1:0] avAddress,
    input wire logic avRead,
    input wire logic avWrite,
    input wire logic [lcd_port_pkg::DATA_W-1:0] avWriteData,
    input wire logic [3:0] avByteEnable,
    input wire logic [lcd_port_pkg::DATA_W-1:0] avReadData,
    input wire logic avWaitRequest,
    input wire logic [1:0] avResponse,
    input wire logic [3:0] portaPinIn,
    input wire logic [3:0] portaPinOut,
    input wire logic [3:0] portaPinOe,
    input wire logic [3:0] lcdCommonDrive,
    input wire logic [7:0] portbPinIn,
    input wire logic [3:0] portcPinIn
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // A read taken by the idle slave at this edge
    sequence takeRd(logic [15:0] a);
        avRead && avWaitRequest && avAddress == a;
    endsequence
    dir_read_ones_a: assert property (takeRd(IDX_PORTA_DIR) |=> avReadData[7:0] == 8'hff)
        else $error("direction register did not read all ones");
    latch_upper_a: assert property (takeRd(IDX_PORTA_LATCH) |=> avReadData[7:4] == 4'hf)
        else $error("port A upper bits not one");
    portb_level_a: assert property (takeRd(IDX_PORTB_LEVELS) |=>
        (avReadData[7:0] & ~$past(portbPinIn)) == 8'h00)
        else $error("port B read a one on a low pin");
    portc_level_a: assert property (takeRd(IDX_PORTC_LEVELS) |=>
        (avReadData[3:0] & ~$past(portcPinIn)) == 4'h0)
        else $error("port C read a one on a low pin");
    portc_upper_a: assert property (takeRd(IDX_PORTC_LEVELS) |=> avReadData[7:4] == 4'h0)
        else $error("port C upper bits not zero");
    portb_resp_a: assert property (takeRd(IDX_PORTB_LEVELS) |=> avResponse == 2'h0)
        else $error("port B read refused");
    reset_float_a: assert property ($rose(arst_n) |-> portaPinOe == 4'h0)
        else $error("port A driven right after reset");
    one_answer_a: assert property (avWaitRequest && (avRead || avWrite) |=>
        !avWaitRequest ##1 avWaitRequest)
        else $error("register access not answered in one cycle");
endmodule : lcd_shared_io_ports_checker

bind lcd_shared_io_ports lcd_shared_io_ports_checker i_chk (.sys_clk, .arst_n, .avAddress,
    .avRead, .avWrite, .avWriteData, .avByteEnable, .avReadData, .avWaitRequest, .avResponse,
    .portaPinIn, .portaPinOut, .portaPinOe, .lcdCommonDrive, .portbPinIn, .portcPinIn);

// ### dv/pin_world_model.sv
`timescale 1ns/1ps
module pin_world_model #(
    parameter logic [3:0] COMMON_PATTERN = 4'h5
) (
    input wire logic [3:0] portaPinOut,
    input wire logic [3:0] portaPinOe,
    input wire logic [3:0] extLevel,
    output logic [3:0] portaPinIn,
    output logic [3:0] lcdCommonDrive
);
    assign lcdCommonDrive = COMMON_PATTERN;
    // An outside source always drives undriven pins, so no pin is left floating
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            portaPinIn[i] = portaPinOe[i] ? portaPinOut[i] : extLevel[i];
        end
    end
endmodule : pin_world_model

// ### dv/tb_lcd_shared_io_ports.sv
`timescale 1ns/1ps
module tb_lcd_shared_io_ports;
    import lcd_port_pkg::*;
    typedef struct {logic [15:0] a; logic w; logic [7:0] d; logic [7:0] pb; logic [3:0] pc;
        logic [3:0] pa; logic [7:0] e;} row_t;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] avAddress = 16'h0000;
    logic avRead = 1'b0;
    logic avWrite = 1'b0;
    logic [31:0] avWriteData = 32'h0;
    logic [3:0] avByteEnable = 4'h1;
    logic [31:0] avReadData;
    logic avWaitRequest;
    logic [1:0] avResponse;
    logic [3:0] portaPinIn, portaPinOut, portaPinOe, lcdCommonDrive;
    logic [3:0] extLevel = 4'h0;
    logic [3:0] portcPinIn = 4'h0;
    logic [7:0] portbPinIn = 8'h00;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [3:0] m;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    row_t rows[14] = '{'{IDX_PORTA_LATCH, 0, 0, 0, 0, 4'h5, 8'hf5},
        '{IDX_PORTA_DIR, 0, 0, 0, 0, 0, 8'hff}, '{IDX_PORTA_DIR, 1, 8'h0f, 0, 0, 0, 0},
        '{IDX_PORTA_LATCH, 0, 0, 0, 0, 4'h5, 8'hf0}, '{IDX_PORTA_LATCH, 1, 8'h0a, 0, 0, 0, 0},
        '{IDX_PORTA_DIR, 1, 8'h03, 0, 0, 0, 0}, '{IDX_PORTA_LATCH, 0, 0, 0, 0, 4'h4, 8'hf6},
        '{IDX_PORTB_LEVELS, 0, 0, 8'ha5, 0, 0, 8'ha5}, '{IDX_CONV_MODE, 1, 8'h05, 0, 0, 0, 0},
        '{IDX_PORTB_LEVELS, 0, 0, 8'hff, 0, 0, 8'hfd}, '{IDX_CONV_MODE, 1, 8'h0e, 0, 0, 0, 0},
        '{IDX_PORTC_LEVELS, 0, 0, 0, 4'hf, 0, 8'h0b}, '{IDX_PORTB_LEVELS, 0, 0, 8'hff, 0, 0, 8'hff},
        '{16'h1234, 0, 0, 0, 0, 0, 8'h00}};
    logic [7:0] cfgs[8] = '{8'h00, 8'h10, 8'h01, 8'h41, 8'h81, 8'hc1, 8'h21, 8'h40};

    lcd_shared_io_ports i_lcd_shared_io_ports (.sys_clk, .arst_n, .avAddress, .avRead, .avWrite,
        .avWriteData, .avByteEnable, .avReadData, .avWaitRequest, .avResponse, .portaPinIn,
        .portaPinOut, .portaPinOe, .lcdCommonDrive, .portbPinIn, .portcPinIn);
    pin_world_model i_pin_world_model (.portaPinOut, .portaPinOe, .extLevel, .portaPinIn,
        .lcdCommonDrive);

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    always @(posedge sys_clk) begin
        cycles++;
        // Whole run needs well under a thousand cycles
        if (cycles == 3000) begin
            bad_count++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
        avAddress <= a;
        avWrite <= w;
        avRead <= !w;
        avWriteData <= {24'h0, d};
        do @(posedge sys_clk); while (avWaitRequest !== 1'b0);
        rd = avReadData;
        rsp = avResponse;
        avRead <= 1'b0;
        avWrite <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    task automatic settle();
        repeat (2) @(posedge sys_clk);
    endtask : settle

    initial begin
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        foreach (rows[i]) begin
            portbPinIn <= rows[i].pb;
            portcPinIn <= rows[i].pc;
            extLevel <= rows[i].pa;
            bus(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) check({24'h0, rd[7:0]}, {24'h0, rows[i].e});
            check({30'h0, rsp}, (rows[i].a == 16'h1234) ? 32'h3 : 32'h0);
        end
        $display("register table done");
        // Direction 03 and latch a are in place from the table
        foreach (cfgs[i]) begin
            bus(IDX_LCD_PORT_CTRL, 1'b1, cfgs[i]);
            settle();
            m[0] = cfgs[i][4] || cfgs[i][3:0] != 4'h0;
            m[1] = m[0] && (cfgs[i][5] || cfgs[i][7:6] != 2'b00);
            m[2] = m[0] && (cfgs[i][5] || cfgs[i][7]);
            m[3] = m[0] && (cfgs[i][5] || cfgs[i][7:6] == 2'b11);
            check(portaPinOe, m | 4'h3);
            check(portaPinOut, (m & lcdCommonDrive) | (~m & 4'ha));
        end
        $display("lcd sharing done");
        foreach (cfgs[i]) begin
            if (i < 3) begin
                bus(IDX_POWER_MODE, 1'b1, (i == 2) ? 8'h04 : 8'(i + 1));
                bus(IDX_PORTA_DIR, 1'b1, 8'h0c);
                settle();
                check(portaPinOe, 4'h3);
            end
        end
        bus(IDX_POWER_MODE, 1'b1, 8'h03);
        settle();
        check(portaPinOe, 4'h0);
        bus(IDX_POWER_MODE, 1'b1, 8'h05);
        settle();
        check(portaPinOe, 4'hc);
        $display("power modes done");
        arst_n <= 1'b0;
        @(posedge sys_clk);
        check(portaPinOe, 4'h0);
        arst_n <= 1'b1;
        extLevel <= 4'h9;
        @(posedge sys_clk);
        bus(IDX_PORTA_LATCH, 1'b0, 8'h00);
        check(rd, 32'hf9);
        avByteEnable <= 4'h0;
        bus(IDX_PORTA_DIR, 1'b1, 8'h0f);
        avByteEnable <= 4'h1;
        settle();
        check(portaPinOe, 4'h0);
        $display("mid-run reset done");
        results();
    end
endmodule : tb_lcd_shared_io_ports
